// [verilog/sm_solo_ctrl.v]
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sm_defs.vh"
// Overview of operation
// - Talkback live only while talk held
// - Independent talkback enables to every bus
// - Monitor carries master unless solo active
// - Headphone mute from button or screen
// - Separate monitor mute from button or screen
// - Mono sum from button or screen
// - Without hold, solos are mutually exclusive
// - With hold, each press toggles solo
// - Clear drops every active solo
// - Softkeys act exactly like hold, clear
// - Four category pre/post fade modes
// - Pre-fade tap ignores fader and mute
// - Stereo pre-fade solo is mono sum
// - Post-fade tap follows fader and pan
// - Aux solo always mono, tap per mode
// - Separate pre and post solo trims
// - Solo feeds monitors, mono sum, headphones
// - Destructive mode mutes unsoloed inputs while an input is soloed
// - Destructive toggle: 3 s hold or click
module sm_solo_ctrl #(
  parameter [31:0] SIP_HOLD_CYC = `SM_SIP_HOLD_MS * `SM_CLK_KHZ,
  parameter        HOLD_INIT    = 1'b0,
  parameter        SIP_INIT     = 1'b0
) (
  input  wire                  core_clk,
  input  wire                  rst_n,
  // AXI4-Lite slave
  input  wire [`SM_ADDR_W-1:0] s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output wire                  s_axi_awready,
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output wire                  s_axi_wready,
  output wire [1:0]            s_axi_bresp,
  output wire                  s_axi_bvalid,
  input  wire                  s_axi_bready,
  input  wire [`SM_ADDR_W-1:0] s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output wire                  s_axi_arready,
  output wire [31:0]           s_axi_rdata,
  output wire [1:0]            s_axi_rresp,
  output wire                  s_axi_rvalid,
  input  wire                  s_axi_rready,
  // Panel buttons, asynchronous, high while pressed
  input  wire                  talk_btn,
  input  wire                  hold_btn,
  input  wire                  clear_btn,
  input  wire                  sip_btn,
  input  wire                  hp_mute_btn,
  input  wire                  mon_mute_btn,
  input  wire                  sum_btn,
  input  wire [`SM_NSOLO-1:0]  solo_btn,
  // Routing fabric controls
  output wire                  talk_en,
  output wire [`SM_TB_W-1:0]   tb_route_en,
  output wire                  mon_from_solo,
  output wire                  hp_mute,
  output wire                  mon_mute,
  output wire                  mono_monitor_out,
  output wire                  solo_to_hp,
  output wire                  solo_to_mono_out,
  output wire [`SM_NSOLO-1:0]  solo_active,
  output wire [`SM_NSOLO-1:0]  solo_post_tap,
  output wire [`SM_NSOLO-1:0]  solo_sum_mono,
  output wire [7:0]            pre_fader_solo_trim,
  output wire [7:0]            post_fader_solo_trim,
  output wire                  destructive_solo_mode,
  output wire [`SM_NIN-1:0]    sip_mute
);

  // Synchronised buttons and their previous values
  localparam NB = 6;
  wire [NB-1:0]        btn_s;      // Hold, clear, hp, mon, sum, talk
  wire [`SM_NSOLO-1:0] solo_s;     // Solo buttons, synchronised
  reg  [NB-1:0]        btn_d_ff;   // Previous sample
  reg  [`SM_NSOLO-1:0] solo_d_ff;  // Previous sample
  wire [NB-1:0]        btn_rise;
  wire [`SM_NSOLO-1:0] solo_rise;
  wire                 sip_s;
  wire                 sip_long;   // Long-press firing

  sm_sync #(.W(NB)) u_sync_btn (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      ({talk_btn, sum_btn, mon_mute_btn,
                hp_mute_btn, clear_btn, hold_btn}),
    .dout     (btn_s)
  );

  sm_sync #(.W(`SM_NSOLO + 1)) u_sync_solo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      ({sip_btn, solo_btn}),
    .dout     ({sip_s, solo_s})
  );

  sm_press_timer #(.HOLD_CYC(SIP_HOLD_CYC)) u_sip_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .held     (sip_s),
    .fire     (sip_long)
  );

  // Edge history for press detection
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_d_ff  <= {NB{1'b0}};
      solo_d_ff <= {`SM_NSOLO{1'b0}};
    end else begin
      btn_d_ff  <= btn_s;
      solo_d_ff <= solo_s;
    end
  end

  assign btn_rise  = btn_s & ~btn_d_ff;
  assign solo_rise = solo_s & ~solo_d_ff;

  // Bus side state
  reg [`SM_ADDR_W-1:0] awaddr_ff;  // Latched write address
  reg                  aw_hold_ff; // Address held, waiting data
  reg [31:0]           wdata_ff;   // Latched write data
  reg [3:0]            wstrb_ff;
  reg                  w_hold_ff;  // Data held, waiting address
  reg                  bvalid_ff;
  reg [1:0]            bresp_ff;
  reg                  rvalid_ff;
  reg [31:0]           rdata_ff;
  reg [1:0]            rresp_ff;

  // Block state
  reg [4:0]            ctrl_ff;    // Hold, sip, hp, mon, mono
  reg [3:0]            mode_ff;    // 1 = post-fade per category
  reg                  sum_ff;     // Latched SUM button
  reg [`SM_TB_W-1:0]   tbrt_ff;    // Talkback route selects
  reg [7:0]            pre_trim_ff;
  reg [7:0]            post_trim_ff;
  reg [`SM_NSOLO-1:0]  solo_ff;    // Active solo selections
  reg                  talk_ff;    // Talk path enable

  // A write fires once both halves are in hand
  wire aw_take  = s_axi_awvalid & ~aw_hold_ff & ~bvalid_ff;
  wire w_take   = s_axi_wvalid & ~w_hold_ff & ~bvalid_ff;
  wire have_aw  = aw_hold_ff | aw_take;
  wire have_w   = w_hold_ff | w_take;
  wire wr_fire  = have_aw & have_w;
  wire [`SM_ADDR_W-1:0] wr_addr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0]           wr_data = w_hold_ff ? wdata_ff : s_axi_wdata;
  wire [3:0]            wr_strb = w_hold_ff ? wstrb_ff : s_axi_wstrb;

  assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_hold_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Write address decode
  wire wr_ctrl = wr_fire & (wr_addr == `SM_OFF_CTRL);
  wire wr_tbrt = wr_fire & (wr_addr == `SM_OFF_TBRT);
  wire wr_trim = wr_fire & (wr_addr == `SM_OFF_TRIM);
  wire wr_cmd  = wr_fire & (wr_addr == `SM_OFF_CMD);
  wire wr_solo = wr_fire & (wr_addr == `SM_OFF_SOLO);
  wire wr_ok   = wr_ctrl | wr_tbrt | wr_trim | wr_cmd | wr_solo |
                 (wr_addr == `SM_OFF_STAT);

  // Command strobes need byte lane zero
  wire cmd_clr  = wr_cmd & wr_strb[0] & wr_data[`SM_C_CLR];
  wire cmd_hold = wr_cmd & wr_strb[0] & wr_data[`SM_C_HOLD];
  wire cmd_sip  = wr_cmd & wr_strb[0] & wr_data[`SM_C_SIP];

  // Button or softkey have the same effect
  wire hold_tgl = btn_rise[0] | cmd_hold;
  wire clr_req  = btn_rise[1] | cmd_clr;
  wire sip_tgl  = sip_long | cmd_sip;

  // Solo presses: panel edges or on-screen solo strobes
  wire [`SM_NSOLO-1:0] sw_press = wr_solo ? wr_data[`SM_NSOLO-1:0]
                                          : {`SM_NSOLO{1'b0}};
  wire [`SM_NSOLO-1:0] press    = solo_rise | sw_press;
  // Lowest pressed source wins when two arrive together
  wire [`SM_NSOLO-1:0] press_1h = press & (~press + `SM_NSOLO'h1);

  // Write channel handshake and response
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      awaddr_ff  <= {`SM_ADDR_W{1'b0}};
      aw_hold_ff <= 1'b0;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
      w_hold_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `SM_RESP_OK;
    end else begin
      if (wr_fire) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        // Unmapped offsets answer with a slave error
        bresp_ff   <= wr_ok ? `SM_RESP_OK : `SM_RESP_ERR;
      end else begin
        if (aw_take) begin
          aw_hold_ff <= 1'b1;
          awaddr_ff  <= s_axi_awaddr;
        end
        if (w_take) begin
          w_hold_ff <= 1'b1;
          wdata_ff  <= s_axi_wdata;
          wstrb_ff  <= s_axi_wstrb;
        end
        if (bvalid_ff && s_axi_bready) begin
          bvalid_ff <= 1'b0;
        end
      end
    end
  end

  // Read data assembly
  reg [31:0] rd_val;
  reg        rd_ok;
  always @* begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    if (s_axi_araddr == `SM_OFF_CTRL) begin
      rd_val[4:0] = ctrl_ff;
      rd_val[`SM_MODE_MSB:`SM_MODE_LSB] = mode_ff;
    end else if (s_axi_araddr == `SM_OFF_TBRT) begin
      rd_val[`SM_TB_W-1:0] = tbrt_ff;
    end else if (s_axi_araddr == `SM_OFF_TRIM) begin
      rd_val[`SM_PRE_MSB:`SM_PRE_LSB]   = pre_trim_ff;
      rd_val[`SM_POST_MSB:`SM_POST_LSB] = post_trim_ff;
    end else if (s_axi_araddr == `SM_OFF_CMD) begin
      // Strobes only, always read as zero
      rd_val = 32'h0;
    end else if (s_axi_araddr == `SM_OFF_SOLO) begin
      rd_val[`SM_NSOLO-1:0] = solo_ff;
    end else if (s_axi_araddr == `SM_OFF_STAT) begin
      rd_val[`SM_S_ANY]  = |solo_ff;
      rd_val[`SM_S_TALK] = talk_ff;
      rd_val[`SM_S_SUM]  = sum_ff;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Read channel, one cycle to answer
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= `SM_RESP_OK;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_val;
      rresp_ff  <= rd_ok ? `SM_RESP_OK : `SM_RESP_ERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Monitor controls: a panel press toggles, software sets
  reg [4:0] nxt_ctrl;
  always @* begin
    nxt_ctrl = ctrl_ff;
    if (btn_rise[2]) begin
      nxt_ctrl[`SM_B_HPM] = ~ctrl_ff[`SM_B_HPM];
    end
    if (btn_rise[3]) begin
      nxt_ctrl[`SM_B_MONM] = ~ctrl_ff[`SM_B_MONM];
    end
    // On-screen writes; hold and sip stay toggle-only
    if (wr_ctrl && wr_strb[0]) begin
      nxt_ctrl[`SM_B_HPM]  = wr_data[`SM_B_HPM];
      nxt_ctrl[`SM_B_MONM] = wr_data[`SM_B_MONM];
      nxt_ctrl[`SM_B_MONO] = wr_data[`SM_B_MONO];
    end
    if (hold_tgl) begin
      nxt_ctrl[`SM_B_HOLD] = ~ctrl_ff[`SM_B_HOLD];
    end
    if (sip_tgl) begin
      nxt_ctrl[`SM_B_SIP] = ~ctrl_ff[`SM_B_SIP];
    end
  end

  // Solo selection update
  reg [`SM_NSOLO-1:0] nxt_solo;
  always @* begin
    nxt_solo = solo_ff;
    // Clear first, so a press in the same cycle still lands
    if (clr_req) begin
      nxt_solo = {`SM_NSOLO{1'b0}};
    end
    if (ctrl_ff[`SM_B_HOLD]) begin
      nxt_solo = nxt_solo ^ press;
    end else if (|press) begin
      // Interlock; pressing the live solo again releases it
      if (|(press_1h & nxt_solo)) begin
        nxt_solo = {`SM_NSOLO{1'b0}};
      end else begin
        nxt_solo = press_1h;
      end
    end
  end

  // Block state registers
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Solos empty, hold and sip from stored setting
      ctrl_ff      <= {3'b000, SIP_INIT, HOLD_INIT};
      solo_ff      <= {`SM_NSOLO{1'b0}};
      mode_ff      <= 4'h0;
      sum_ff       <= 1'b0;
      tbrt_ff      <= {`SM_TB_W{1'b0}};
      pre_trim_ff  <= `SM_TRIM_RST;
      post_trim_ff <= `SM_TRIM_RST;
      talk_ff      <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      solo_ff <= nxt_solo;
      // Talk is momentary: follows the button level
      talk_ff <= btn_s[5];
      if (btn_rise[4]) begin
        sum_ff <= ~sum_ff;
      end
      if (wr_ctrl && wr_strb[1]) begin
        mode_ff <= wr_data[`SM_MODE_MSB:`SM_MODE_LSB];
      end
      if (wr_tbrt) begin
        tbrt_ff <= wr_data[`SM_TB_W-1:0];
      end
      if (wr_trim && wr_strb[0]) begin
        pre_trim_ff <= wr_data[`SM_PRE_MSB:`SM_PRE_LSB];
      end
      if (wr_trim && wr_strb[1]) begin
        post_trim_ff <= wr_data[`SM_POST_MSB:`SM_POST_LSB];
      end
    end
  end

  // Per-source tap point and mono summing by category
  genvar i;
  generate
    for (i = 0; i < `SM_NSOLO; i = i + 1) begin : g_src
      localparam CAT = (i < `SM_ST_LO)  ? `SM_CAT_MONO :
                       (i < `SM_AUX_LO) ? `SM_CAT_ST   :
                       (i < `SM_GRP_LO) ? `SM_CAT_AUX  : `SM_CAT_GRP;
      // Post tap after fader and pan, pre tap before fader
      assign solo_post_tap[i] = mode_ff[CAT];
      if (CAT == `SM_CAT_AUX) begin : g_aux
        assign solo_sum_mono[i] = 1'b1;
      end else if (CAT == `SM_CAT_ST) begin : g_st
        assign solo_sum_mono[i] = ~mode_ff[CAT];
      end else begin : g_other
        assign solo_sum_mono[i] = 1'b0;
      end
      if (i < `SM_NIN) begin : g_in
        // Only inputs are muted, and only by a solo on another input
        assign sip_mute[i] = ctrl_ff[`SM_B_SIP] &
                             (|solo_ff[`SM_NIN-1:0]) &
                             ~solo_ff[i];
      end
    end
  endgenerate

  wire any_solo = |solo_ff;

  // Fabric outputs
  assign talk_en               = talk_ff;
  // Routes gated by talk so no bus hears an idle mic
  assign tb_route_en           = talk_ff ? tbrt_ff
                                         : {`SM_TB_W{1'b0}};
  assign mon_from_solo         = any_solo;
  assign solo_to_hp            = any_solo;
  assign solo_to_mono_out      = any_solo;
  assign hp_mute               = ctrl_ff[`SM_B_HPM];
  assign mon_mute              = ctrl_ff[`SM_B_MONM];
  assign mono_monitor_out      = ctrl_ff[`SM_B_MONO] | sum_ff;
  assign solo_active           = solo_ff;
  assign pre_fader_solo_trim   = pre_trim_ff;
  assign post_fader_solo_trim  = post_trim_ff;
  assign destructive_solo_mode = ctrl_ff[`SM_B_SIP];

endmodule

// [verilog/sm_defs.vh]
`ifndef SM_DEFS_VH
`define SM_DEFS_VH

// Register byte offsets on the AXI4-Lite slave
`define SM_ADDR_W     5
`define SM_OFF_CTRL   5'h00
`define SM_OFF_TBRT   5'h04
`define SM_OFF_TRIM   5'h08
`define SM_OFF_CMD    5'h0c
`define SM_OFF_SOLO   5'h10
`define SM_OFF_STAT   5'h14

// Control register fields
`define SM_B_HOLD     0
`define SM_B_SIP      1
`define SM_B_HPM      2
`define SM_B_MONM     3
`define SM_B_MONO     4
`define SM_MODE_LSB   8
`define SM_MODE_MSB   11

// Command register strobes (write one)
`define SM_C_CLR      0
`define SM_C_HOLD     1
`define SM_C_SIP      2

// Status register fields
`define SM_S_ANY      0
`define SM_S_TALK     1
`define SM_S_SUM      2

// Trim fields
`define SM_PRE_LSB    0
`define SM_PRE_MSB    7
`define SM_POST_LSB   8
`define SM_POST_MSB   15
`define SM_TRIM_RST   8'h00

// Solo sources: mono 0-7, stereo 8-11, aux 12-19, groups 20-23
`define SM_NSOLO      24
`define SM_NIN        12
`define SM_ST_LO      8
`define SM_AUX_LO     12
`define SM_GRP_LO     20
`define SM_CAT_MONO   0
`define SM_CAT_ST     1
`define SM_CAT_AUX    2
`define SM_CAT_GRP    3

// Talkback routes: L, R, groups 1-4, aux 1-8
`define SM_TB_W       14

// Bus answers
`define SM_RESP_OK    2'b00
`define SM_RESP_ERR   2'b10

// Long press for destructive solo toggle
`define SM_SIP_HOLD_MS 3000
`define SM_CLK_KHZ     100000

`endif

// [verilog/sm_sync.v]
`timescale 1ns/1ps
// Two-stage synchroniser, one chain per bit
module sm_sync #(
  parameter W = 1
) (
  input  wire         core_clk,
  input  wire         rst_n,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_ff;  // First stage, read only by second
      reg sync_ff;  // Second stage, safe to use
      // Plain double flop per pin
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= din[i];
          sync_ff <= meta_ff;
        end
      end
      assign dout[i] = sync_ff;
    end
  endgenerate
endmodule

// [verilog/sm_press_timer.v]
`timescale 1ns/1ps
// Fires once when a button has been held for HOLD_CYC cycles
module sm_press_timer #(
  parameter [31:0] HOLD_CYC = 32'd300000000
) (
  input  wire core_clk,
  input  wire rst_n,
  input  wire held,
  output wire fire
);
  reg  [31:0] cnt_ff;   // Cycles held so far, saturates
  reg  [31:0] nxt_cnt;
  reg         fire_ff;  // One-cycle firing pulse
  reg         nxt_fire;

  // Count while held; a release restarts the wait
  always @* begin
    nxt_cnt  = cnt_ff;
    nxt_fire = 1'b0;
    if (!held) begin
      nxt_cnt = 32'h0;
    end else if (cnt_ff < HOLD_CYC) begin
      nxt_cnt = cnt_ff + 32'h1;
      // Only one firing per press, however long it is held
      nxt_fire = (nxt_cnt == HOLD_CYC);
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= 32'h0;
      fire_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      fire_ff <= nxt_fire;
    end
  end

  assign fire = fire_ff;
endmodule

// [dv/sm_solo_ctrl_assertions.sv]
`timescale 1ns/1ps
`include "sm_defs.vh"
// Watches the fabric-side outputs against the button and bus inputs
module sm_solo_ctrl_chk (
  input wire                 core_clk,
  input wire                 rst_n,
  input wire                 s_axi_wvalid,
  input wire                 talk_btn,
  input wire                 clear_btn,
  input wire                 hp_mute_btn,
  input wire                 mon_mute_btn,
  input wire [`SM_NSOLO-1:0] solo_btn,
  input wire                 talk_en,
  input wire [`SM_TB_W-1:0]  tb_route_en,
  input wire                 mon_from_solo,
  input wire                 hp_mute,
  input wire                 mon_mute,
  input wire                 solo_to_hp,
  input wire                 solo_to_mono_out,
  input wire [`SM_NSOLO-1:0] solo_active,
  input wire [`SM_NSOLO-1:0] solo_post_tap,
  input wire [`SM_NSOLO-1:0] solo_sum_mono,
  input wire                 destructive_solo_mode,
  input wire [`SM_NIN-1:0]   sip_mute
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // No solo press and no software write racing a clear
  wire quiet     = solo_btn == 24'h0 && !s_axi_wvalid;
  wire any_solo  = |solo_active;

  a_talk_on: assert property (talk_btn [*4] |-> talk_en)
    else $error("talk path off while talk held");
  a_talk_off: assert property (!talk_btn [*4] |-> !talk_en)
    else $error("talk path live after release");
  a_route_gate: assert property (tb_route_en != 14'h0 |-> talk_en)
    else $error("talkback routed while talk idle");
  a_mon_source: assert property (mon_from_solo == any_solo
    && solo_to_hp == any_solo && solo_to_mono_out == any_solo)
    else $error("monitor source disagrees with solo state");
  a_sip_mute: assert property (sip_mute ==
    ((destructive_solo_mode && |solo_active[11:0]) ?
     ~solo_active[11:0] : 12'h0))
    else $error("input mutes wrong for destructive solo");
  a_sum_map: assert property (solo_sum_mono[19:12] == 8'hff
    && solo_sum_mono[11:8] == ~solo_post_tap[11:8]
    && solo_sum_mono[7:0] == 8'h0 && solo_sum_mono[23:20] == 4'h0)
    else $error("mono sum map wrong");
  a_tap_group: assert property (solo_post_tap[7:0] inside {8'h0, 8'hff}
    && solo_post_tap[11:8] inside {4'h0, 4'hf}
    && solo_post_tap[19:12] inside {8'h0, 8'hff}
    && solo_post_tap[23:20] inside {4'h0, 4'hf})
    else $error("tap mode not uniform per category");
  a_clear_all: assert property (($rose(clear_btn) && quiet)
    ##1 quiet [*3] |-> solo_active == 24'h0)
    else $error("clear left a solo active");
  a_hp_steady: assert property ((!s_axi_wvalid &&
    $stable(hp_mute_btn)) [*6] |=> $stable(hp_mute))
    else $error("headphone mute moved without cause");
  a_mon_steady: assert property ((!s_axi_wvalid &&
    $stable(mon_mute_btn)) [*6] |=> $stable(mon_mute))
    else $error("monitor mute moved without cause");

  c_multi: cover property ($countones(solo_active) > 1);
  c_sip: cover property ($rose(destructive_solo_mode));
  c_talk: cover property ($rose(talk_en) ##[1:50] $fell(talk_en));
endmodule

// Every checker port shares its name with a port of the block
bind sm_solo_ctrl sm_solo_ctrl_chk i_sm_solo_ctrl_chk (.*);

// [dv/sm_panel_model.sv]
`timescale 1ns/1ps
// Operator panel: every button is a level, high while pressed
module sm_panel_model (
  input  wire        core_clk,
  output wire [23:0] solo_btn,
  output wire        talk_btn,
  output wire        hold_btn,
  output wire        clear_btn,
  output wire        sip_btn,
  output wire        hp_mute_btn,
  output wire        mon_mute_btn,
  output wire        sum_btn
);
  // Bits 0-23 solo, then talk, hold, clear, sip, hp, mon, sum
  logic [30:0] key_ff = 31'h0;
  assign solo_btn = key_ff[23:0];
  assign {sum_btn, mon_mute_btn, hp_mute_btn, sip_btn,
          clear_btn, hold_btn, talk_btn} = key_ff[30:24];
  // Press n cycles, then wait out the sync and edge pipe
  task automatic tap(input int k, input int n);
    @(posedge core_clk);
    key_ff[k] <= 1'b1;
    repeat (n) @(posedge core_clk);
    key_ff[k] <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
  endtask
  // Momentary keys such as talk stay down while held
  task automatic level(input int k, input logic v);
    @(posedge core_clk);
    key_ff[k] <= v;
    repeat (6) @(posedge core_clk);
    #1;
  endtask
endmodule

// [dv/sm_solo_ctrl_test.sv]
`timescale 1ns/1ps
`include "sm_defs.vh"
module sm_solo_ctrl_test;
  // Panel key indices beyond the 24 solo keys
  localparam K_TALK = 24, K_HOLD = 25, K_CLR = 26, K_SIP = 27;
  localparam K_HP = 28, K_MON = 29, K_SUM = 30;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic [4:0]  awaddr   = 5'h0;
  logic [4:0]  araddr   = 5'h0;
  logic [31:0] wdata    = 32'h0;
  logic        awvalid  = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid  = 1'b0, rready = 1'b0;
  logic [23:0] et, es;   // Expected tap and mono-sum vectors
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [23:0] solo_btn, solo_active, solo_post_tap, solo_sum_mono;
  wire         talk_btn, hold_btn, clear_btn, sip_btn;
  wire         hp_mute_btn, mon_mute_btn, sum_btn;
  wire         talk_en, mon_from_solo, hp_mute, mon_mute;
  wire         mono_monitor_out, solo_to_hp, solo_to_mono_out;
  wire         destructive_solo_mode;
  wire  [13:0] tb_route_en;
  wire  [7:0]  pre_fader_solo_trim, post_fader_solo_trim;
  wire  [11:0] sip_mute;
  int          fail_count = 0, tests_run = 0, cycles = 0;

  // Short long-press so the destructive toggle fits the run
  sm_solo_ctrl #(.SIP_HOLD_CYC(32'd20)) i_sm_solo_ctrl (
    .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .*);

  // Panel and fabric nets carry the port names of both modules
  sm_panel_model i_sm_panel_model (.*);

  // 100 MHz clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // Four-state compare, an unknown matches only an unknown
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
    // Let the register update reach the outputs
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // Read: response taken at the edge where rvalid is seen
  task automatic rd(input logic [4:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rresp", er, rresp);
    chk("rdata", ed, rdata);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, run needs a few hundred cycles
  initial begin
    forever begin
      @(posedge core_clk);
      cycles++;
      if (cycles == 20000) begin
        fail_count++;
        end_sim();
      end
    end
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(5'h00, 32'h0, 2'b00);
    chk("solo", 24'h0, solo_active);
    chk("sip", 1'b0, destructive_solo_mode);
    // Unmapped offset refused both ways
    rd(5'h18, 32'h0, 2'b10);
    wr(5'h18, 32'h1, 2'b10);
    wr(5'h04, 32'h2a55, 2'b00);
    chk("route", 14'h0, tb_route_en);
    i_sm_panel_model.level(K_TALK, 1'b1);
    chk("talk", 1'b1, talk_en);
    chk("route", 14'h2a55, tb_route_en);
    i_sm_panel_model.level(K_TALK, 1'b0);
    chk("talk", 1'b0, talk_en);
    // Mutes toggle from buttons, set from software
    i_sm_panel_model.tap(K_HP, 3);
    chk("hp", 1'b1, hp_mute);
    chk("mon", 1'b0, mon_mute);
    i_sm_panel_model.tap(K_MON, 3);
    chk("mon", 1'b1, mon_mute);
    wr(5'h00, 32'h4, 2'b00);
    chk("hp", 1'b1, hp_mute);
    chk("mon", 1'b0, mon_mute);
    wr(5'h00, 32'h10, 2'b00);
    chk("mono", 1'b1, mono_monitor_out);
    chk("hp", 1'b0, hp_mute);
    wr(5'h00, 32'h0, 2'b00);
    chk("mono", 1'b0, mono_monitor_out);
    i_sm_panel_model.tap(K_SUM, 3);
    chk("mono", 1'b1, mono_monitor_out);
    i_sm_panel_model.tap(K_SUM, 3);
    chk("mono", 1'b0, mono_monitor_out);
    // Each category alone in post-fade mode
    for (int c = 0; c < 4; c++) begin
      wr(5'h00, 32'h100 << c, 2'b00);
      et = 24'h0;
      es = 24'h0ff000;
      for (int i = 0; i < 24; i++) begin
        et[i] = (((i < 8) ? 0 : (i < 12) ? 1 : (i < 20) ? 2 : 3) == c);
      end
      if (c != 1) es[11:8] = 4'hf;
      chk("tap", et, solo_post_tap);
      chk("sum", es, solo_sum_mono);
    end
    wr(5'h00, 32'h0, 2'b00);
    wr(5'h08, 32'hab12, 2'b00);
    chk("pre", 8'h12, pre_fader_solo_trim);
    chk("post", 8'hab, post_fader_solo_trim);
    rd(5'h08, 32'hab12, 2'b00);
    // Interlocking solos
    i_sm_panel_model.tap(0, 3);
    chk("solo", 24'h1, solo_active);
    chk("monsrc", 1'b1, mon_from_solo);
    chk("feeds", 2'b11, {solo_to_hp, solo_to_mono_out});
    i_sm_panel_model.tap(23, 3);
    chk("solo", 24'h800000, solo_active);
    i_sm_panel_model.tap(23, 3);
    chk("solo", 24'h0, solo_active);
    chk("monsrc", 1'b0, mon_from_solo);
    // Latching solos, panel and screen presses mixed
    i_sm_panel_model.tap(K_HOLD, 3);
    rd(5'h00, 32'h1, 2'b00);
    i_sm_panel_model.tap(3, 3);
    wr(5'h10, 32'h100, 2'b00);
    chk("solo", 24'h108, solo_active);
    i_sm_panel_model.tap(3, 3);
    i_sm_panel_model.tap(12, 3);
    chk("solo", 24'h1100, solo_active);
    i_sm_panel_model.tap(K_CLR, 3);
    chk("solo", 24'h0, solo_active);
    i_sm_panel_model.tap(3, 3);
    wr(5'h0c, 32'h1, 2'b00);
    chk("solo", 24'h0, solo_active);
    wr(5'h0c, 32'h2, 2'b00);
    rd(5'h00, 32'h0, 2'b00);
    // Destructive mode: short press ignored, long press toggles
    i_sm_panel_model.tap(0, 3);
    i_sm_panel_model.tap(K_SIP, 10);
    chk("sip", 1'b0, destructive_solo_mode);
    i_sm_panel_model.tap(K_SIP, 30);
    chk("sip", 1'b1, destructive_solo_mode);
    chk("mutes", 12'hffe, sip_mute);
    i_sm_panel_model.tap(12, 3);
    chk("mutes", 12'h0, sip_mute);
    wr(5'h0c, 32'h4, 2'b00);
    chk("sip", 1'b0, destructive_solo_mode);
    // Second reset in mid-run with a solo active
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("solo", 24'h0, solo_active);
    rd(5'h00, 32'h0, 2'b00);
    end_sim();
  end
endmodule
